/* sim/uled_peer.sv */
/* Link partner model: sends header summaries and link command frames.
   Assumes the bench supplies the link clock and orders the frames. */
`timescale 1ns/1ps
module uled_peer (
  input  wire logic            link_clk_i, // Link clock
  output uled_pkg::uled_hdr_s  hdr_o,      // Header summary
  output uled_pkg::uled_lcmd_s lcmd_o      // Link command frame
);
  import uled_pkg::*;
  initial hdr_o = '0;
  initial lcmd_o = '0;
  // Idle lines show the inverse of the last frame, so stale data never looks held
  task automatic send_hdr(input uled_hdr_s h); // Advert-first order is the bench's job
    @(posedge link_clk_i) hdr_o <= h;
    @(posedge link_clk_i) hdr_o <= {1'b0, ~h[6:0]};
  endtask
  task automatic send_lc(input uled_lcmd_s c); // Sends any command frame; its order against the advert is the bench's job
    @(posedge link_clk_i) lcmd_o <= c;
    @(posedge link_clk_i) lcmd_o <= {1'b0, ~c[21:0]};
  endtask
endmodule

/* sim/uled_sva.sv */
/* Assertions on the link error detector's core-side ports.
   Assumes it is bound into uled_top and watches its ports only. */
`timescale 1ns/1ps
module uled_sva (
  input wire logic                core_clk_i, rst_n_i, in_u0_i, dsp_i, cnt_clr_i,
  input wire logic                pend_hp_to_i, credit_to_i, pm_lc_to_i, lup_miss_i,
  input wire logic                ldn_miss_i, pma_miss_i, recov_req_o, lbad_req_o, ux_delay_o,
  input wire uled_pkg::uled_evt_s evt_o,
  input wire logic [15:0]         link_err_cnt_o, soft_err_cnt_o
);
  import uled_pkg::*;
  // ----------------------------------------------------------------
  // One core domain, so clock and reset are stated once
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_cause(sig);
    in_u0_i && sig;
  endsequence
  chk_pend_recov: assert property (s_cause(pend_hp_to_i) |=> recov_req_o)
    else $error("pending timer expiry without recovery");
  chk_credit_recov: assert property (s_cause(credit_to_i) |=> recov_req_o)
    else $error("credit timer expiry without recovery");
  chk_pm_recov: assert property (s_cause(pm_lc_to_i) |=> recov_req_o)
    else $error("pm timer expiry without recovery");
  chk_role_recov: assert property (s_cause(dsp_i ? lup_miss_i : ldn_miss_i) |=> recov_req_o)
    else $error("missing up or down command without recovery");
  chk_pma_delay: assert property (pma_miss_i |=> ux_delay_o)
    else $error("missing pm ack did not delay entry");
  chk_lbad_cause: assert property (lbad_req_o |-> evt_o.hp_err)
    else $error("lbad without header error");
  chk_seq_recov: assert property (evt_o.seq_err && in_u0_i |-> ##[0:1] recov_req_o)
    else $error("sequence error without recovery");
  chk_cnt_step: assert property (recov_req_o && !$past(cnt_clr_i)
    && $past(link_err_cnt_o) != CNT_MAX |-> link_err_cnt_o == $past(link_err_cnt_o) + 16'h0001)
    else $error("link error count did not step by one");
  chk_cnt_hold: assert property (!recov_req_o && !$past(cnt_clr_i) |-> $stable(link_err_cnt_o))
    else $error("link error count moved without recovery");
  chk_cnt_clear: assert property (cnt_clr_i |=> link_err_cnt_o == CNT_RST && soft_err_cnt_o == CNT_RST)
    else $error("counters not cleared");
endmodule

/* sim/uled_top_bench.sv */
/* Self-checking bench for the link error detector.
   Assumes the peer model drives the link side; the bench drives the core side. */
`timescale 1ns/1ps
module uled_top_bench;
  import uled_pkg::*;
  logic core_clk_i, link_clk_i, rst_n_i, clr, gen2_i, dsp_i, u0_entry_i, in_u0_i, cnt_clr_i;
  logic pend_hp_to_i, credit_to_i, credit2_to_i, pm_lc_to_i, lup_miss_i, ldn_miss_i, pma_miss_i;
  logic sent_adv_i, sent_crd1_i, sent_crd2_i, lbad_req_o, recov_req_o, ux_delay_o, lc_valid_o;
  logic [15:0] link_err_cnt_o, soft_err_cnt_o, exp_cnt;
  logic [10:0] seen;
  uled_evt_s   evt_o;
  uled_hdr_s   hdr_i, h;
  uled_lcmd_s  lcmd_i, c;
  int          error_cnt, n_tests;
  uled_top dut_u (.core_clk_i, .rst_n_i, .link_clk_i, .gen2_i, .dsp_i, .hdr_i, .lcmd_i,
    .u0_entry_i, .in_u0_i, .cnt_clr_i, .pend_hp_to_i, .credit_to_i, .credit2_to_i, .pm_lc_to_i,
    .lup_miss_i, .ldn_miss_i, .pma_miss_i, .sent_adv_i, .sent_crd1_i, .sent_crd2_i,
    .hp_rx_ok_i(1'b0), .lbad_req_o, .recov_req_o, .ux_delay_o, .evt_o, .lc_valid_o,
    .link_err_cnt_o, .soft_err_cnt_o);
  uled_peer peer_u (.link_clk_i, .hdr_o(hdr_i), .lcmd_o(lcmd_i));
  initial begin core_clk_i = 0; forever #50 core_clk_i = ~core_clk_i; end
  initial begin link_clk_i = 0; #7; forever #16 link_clk_i = ~link_clk_i; end
  // Pulses last one cycle, so they are gathered into a sticky vector
  always @(posedge core_clk_i) seen <= clr ? '0 : seen | {lc_valid_o, lbad_req_o, recov_req_o, evt_o};
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, g); end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // m: 0 core pulses only, 1 header h, 2 link command c
  task automatic xfer(input int m, input logic [6:0] t, input logic [10:0] e);
    @(posedge core_clk_i) clr <= 1'b1;
    {pend_hp_to_i, credit_to_i, credit2_to_i, pm_lc_to_i, lup_miss_i, ldn_miss_i, pma_miss_i} <= t;
    @(posedge core_clk_i) clr <= 1'b0;
    {pend_hp_to_i, credit_to_i, credit2_to_i, pm_lc_to_i, lup_miss_i, ldn_miss_i, pma_miss_i} <= '0;
    if (m == 1) peer_u.send_hdr(h);
    if (m == 2) peer_u.send_lc(c);
    repeat (8) @(posedge core_clk_i);
    #1 exp_cnt += 16'(e[8]);
    chk("events", 16'(e), 16'(seen));
    chk("link count", exp_cnt, link_err_cnt_o);
  endtask
  task automatic u0();
    @(posedge core_clk_i) {u0_entry_i, sent_adv_i, sent_crd1_i, sent_crd2_i} <= 4'b1000;
    @(posedge core_clk_i) {u0_entry_i, sent_adv_i, sent_crd1_i, sent_crd2_i} <= 4'b0111;
    @(posedge core_clk_i) {u0_entry_i, sent_adv_i, sent_crd1_i, sent_crd2_i} <= 4'b0000;
    repeat (6) @(posedge core_clk_i);
  endtask
  function automatic uled_hdr_s hd(input logic [2:0] f, input logic [2:0] s);
    return {1'b1, f, 1'b0, s}; // f is crc5 ok, crc16 ok, k-symbol
  endfunction
  function automatic uled_lcmd_s lc(input uled_lc_e k, input logic [2:0] a);
    return {1'b1, 4'hF, 2'b11, k, a, 2'b11, k, a};
  endfunction
  function automatic logic [10:0] lc_exp(input uled_lcmd_s x);
    logic g0, g1;
    g0 = x.w0.defined & x.w0.crc_ok;
    g1 = x.w1.defined & x.w1.crc_ok;
    if ($countones(x.slc_ok) < 3) return 11'h000;
    return ((x.w0 == x.w1 && g0) || (gen2_i && (g0 ^ g1))) ? 11'h400 : 11'h020;
  endfunction
  initial begin #2ms; error_cnt++; print_verdict(); end
  initial begin
    void'($urandom(18020));
    {gen2_i, dsp_i, u0_entry_i, cnt_clr_i, sent_adv_i, sent_crd1_i, sent_crd2_i, clr} = '0;
    {pend_hp_to_i, credit_to_i, credit2_to_i, pm_lc_to_i, lup_miss_i, ldn_miss_i, pma_miss_i} = '0;
    {in_u0_i, rst_n_i, exp_cnt, seen, error_cnt, n_tests} = {2'b10, 27'h0, 64'h0};
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    u0();
    c = lc(ULED_LC_CRD1, 3'h0); xfer(2, 0, 11'h502);
    u0();
    c = lc(ULED_LC_GOOD, 3'h5); xfer(2, 0, 11'h400);
    c = lc(ULED_LC_CRD1, 3'h0); xfer(2, 0, 11'h400);
    c = lc(ULED_LC_GOOD, 3'h6); xfer(2, 0, 11'h400);
    c = lc(ULED_LC_GOOD, 3'h0); xfer(2, 0, 11'h514);
    c = lc(ULED_LC_CRD1, 3'h2); xfer(2, 0, 11'h508);
    u0();
    c = lc(ULED_LC_GOOD, 3'h1); xfer(2, 0, 11'h400);
    h = hd(3'b110, 3'h0); xfer(1, 0, 11'h000);
    h = hd(3'b110, 3'h2); xfer(1, 0, 11'h140);
    h = hd(3'b010, 3'h1); xfer(1, 0, 11'h280);
    h = hd(3'b111, 3'h1); xfer(1, 0, 11'h280);
    h = hd(3'b100, 3'h1); xfer(1, 0, 11'h380);
    c = lc(ULED_LC_GO_UX, 3'h0); xfer(2, 0, 11'h501);
    @(posedge core_clk_i) gen2_i <= 1'b1;
    h = hd(3'b110, 3'h1); xfer(1, 0, 11'h000);
    h = hd(3'b100, 3'h2); xfer(1, 0, 11'h280);
    chk("soft count", 16'h0001, soft_err_cnt_o);
    c = lc(ULED_LC_CRD1, 3'h0); xfer(2, 0, 11'h400);
    c = lc(ULED_LC_GO_UX, 3'h0); xfer(2, 0, 11'h501);
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk_i) gen2_i <= i[0];
      #1;
      c = lc(ULED_LC_OTHER, 3'($urandom));
      {c.w0.defined, c.w0.crc_ok, c.w1.defined, c.w1.crc_ok} = 4'($urandom);
      c.slc_ok = ~(4'($urandom_range(3)) << $urandom_range(2));
      if ($urandom_range(1) == 1) c.w1.arg = 3'($urandom);
      xfer(2, 0, lc_exp(c));
    end
    for (int k = 0; k < 7; k++) begin
      @(posedge core_clk_i) {dsp_i, in_u0_i} <= 2'($urandom);
      #1;
      xfer(0, 7'h40 >> k, {2'b00, in_u0_i & (k == 4 ? dsp_i : k == 5 ? !dsp_i : k != 6), 8'h00});
    end
    @(posedge core_clk_i) cnt_clr_i <= 1'b1;
    @(posedge core_clk_i) cnt_clr_i <= 1'b0;
    @(posedge core_clk_i) #1;
    chk("link count", 16'h0000, link_err_cnt_o);
    chk("soft count", 16'h0000, soft_err_cnt_o);
    print_verdict();
  end
endmodule
bind uled_top uled_sva chk_u (.core_clk_i, .rst_n_i, .in_u0_i, .dsp_i, .cnt_clr_i,
  .pend_hp_to_i, .credit_to_i, .pm_lc_to_i, .lup_miss_i, .ldn_miss_i, .pma_miss_i,
  .recov_req_o, .lbad_req_o, .ux_delay_o, .evt_o, .link_err_cnt_o, .soft_err_cnt_o);

/* verilog/uled_pkg.sv */
/*
  Shared constants and carrier types for the link error detector.
  Assumes the link front end delivers decoded symbols and parsed
  header packets on the link clock, and the state machine sits on core_clk_i.
*/
package uled_pkg;

  // ----------------------------------------------------------------
  // Timing and count constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;   // Core clock rate
  localparam int unsigned HP_FAIL_LIMIT = 3;            // Consecutive header failures
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;     // Saturation of both counters
  localparam logic [15:0] CNT_RST       = 16'h0000;     // Counter value after reset
  localparam logic [2:0]  SEQ_RST       = 3'h0;         // Sequence numbers after reset
  localparam logic [1:0]  LTR_RST       = 2'h0;         // Credit letter after reset
  localparam int unsigned SYM_SLC       = 0;            // Position of SLC flag in a symbol
  localparam int unsigned SYM_EPF       = 1;            // Position of EPF flag in a symbol

  // ----------------------------------------------------------------
  // Link command classes (decoded by the front end)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ULED_LC_NONE, ULED_LC_GOOD, ULED_LC_CRD1, ULED_LC_CRD2, ULED_LC_GO_UX,
    ULED_LC_AU, ULED_LC_XU, ULED_LC_PMA, ULED_LC_UP, ULED_LC_DN, ULED_LC_OTHER
  } uled_lc_e;

  // One copy of a link command word as parsed by the front end
  typedef struct packed {
    logic       defined;   // Encodes a known command
    logic       crc_ok;    // CRC-5 passed
    uled_lc_e   kind;      // Command class
    logic [2:0] arg;       // Sequence number or credit letter
  } uled_lcw_s;

  // Received link command frame
  typedef struct packed {
    logic       strobe;    // One-cycle frame marker
    logic [3:0] slc_ok;    // Per-position frame symbol valid flags
    uled_lcw_s  w0;        // First word copy
    uled_lcw_s  w1;        // Repeated word copy
  } uled_lcmd_s;

  // Received header packet summary
  typedef struct packed {
    logic       strobe;    // One-cycle: start framing set seen
    logic       crc5_ok;   // Link control word CRC passed
    logic       crc16_ok;  // Header CRC passed
    logic       k_sym;     // K-symbol blocked the checks
    logic       type2;     // Packet is a Type 2 packet
    logic [2:0] seq;       // Embedded sequence number
  } uled_hdr_s;

  // Event pulses delivered to the core domain
  typedef struct packed {
    logic hp_err;          // Header packet error
    logic seq_err;         // Rx sequence mismatch
    logic lc_bad;          // Invalid link command discarded
    logic good_miss;       // LGOOD_n out of order
    logic crd_miss;        // Credit letter out of order
    logic ack_err;         // ACK sequence mismatch
    logic adv_err;         // Advertisement ordering error
    logic crd_adv_err;     // Credit advertisement ordering error
  } uled_evt_s;

  localparam int unsigned EVT_W = $bits(uled_evt_s);

endpackage

/* verilog/uled_top.sv */
/*
  Link layer error detector: checks header packets, link commands and
  the U0 entry advertisements, and raises Recovery requests and counts.
  Assumes: symbol and packet parsing lives outside, on link_clk_i; the
  link state machine and timers live on core_clk_i and report expiries
  and state changes as one-cycle pulses.
*/
`timescale 1ns/1ps
module uled_top (
  input  wire logic               core_clk_i,      // Core clock, 10 MHz
  input  wire logic               rst_n_i,         // Async reset, active low
  input  wire logic               link_clk_i,      // Link symbol clock
  input  wire logic               gen2_i,          // Gen 2 operation selected
  input  wire logic               dsp_i,           // Port is downstream facing
  input  wire uled_pkg::uled_hdr_s hdr_i,          // Header packet summary, link clock
  input  wire uled_pkg::uled_lcmd_s lcmd_i,        // Link command frame, link clock
  input  wire logic               u0_entry_i,      // Pulse: U0 entered
  input  wire logic               in_u0_i,         // Level: link in U0
  input  wire logic               cnt_clr_i,       // Pulse: directed counter clear
  input  wire logic               pend_hp_to_i,    // Pulse: PENDING_HP_TIMER expiry
  input  wire logic               credit_to_i,     // Pulse: credit timer expiry
  input  wire logic               credit2_to_i,    // Pulse: Type 2 credit timer expiry
  input  wire logic               pm_lc_to_i,      // Pulse: PM_LC_TIMER expiry
  input  wire logic               lup_miss_i,      // Pulse: LUP missing
  input  wire logic               ldn_miss_i,      // Pulse: LDN missing
  input  wire logic               pma_miss_i,      // Pulse: LPMA missing
  input  wire logic               sent_adv_i,      // Pulse: own sequence advert sent
  input  wire logic               sent_crd1_i,     // Pulse: own (Type 1) credits sent
  input  wire logic               sent_crd2_i,     // Pulse: own Type 2 credits sent
  input  wire logic               hp_rx_ok_i,      // Pulse: header acknowledged by us
  output logic                    lbad_req_o,      // Pulse: send LBAD
  output logic                    recov_req_o,     // Pulse: go to Recovery
  output logic                    ux_delay_o,      // Pulse: delay low power entry
  output uled_pkg::uled_evt_s     evt_o,           // Per-class event pulses
  output logic                    lc_valid_o,      // Pulse: valid link command seen
  output logic [15:0]             link_err_cnt_o,  // Link error count
  output logic [15:0]             soft_err_cnt_o   // Soft error count
);
  import uled_pkg::*;

  // ----------------------------------------------------------------
  // Core-to-link level crossings
  // ----------------------------------------------------------------
  // Gen mode and U0 entry cross as levels/toggle through two flops
  logic [1:0] gen_sync_q;         // Gen 2 synchroniser
  logic       u0_tgl_q;           // U0 entry toggle, core side
  logic [2:0] u0_sync_q;          // U0 toggle synchroniser plus history
  logic       gen2_l;             // Gen 2 mode in link domain
  logic       u0_pulse_l;         // U0 entry pulse in link domain

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      u0_tgl_q <= 1'b0;
    end else if (u0_entry_i) begin
      u0_tgl_q <= ~u0_tgl_q;
    end
  end

  // Link side synchronisers; first stages feed only the second
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_sync_q <= 2'b00;
      u0_sync_q  <= 3'b000;
    end else begin
      gen_sync_q <= {gen_sync_q[0], gen2_i};
      u0_sync_q  <= {u0_sync_q[1:0], u0_tgl_q};
    end
  end

  assign gen2_l     = gen_sync_q[1];
  assign u0_pulse_l = u0_sync_q[2] ^ u0_sync_q[1];

  // ----------------------------------------------------------------
  // Header packet checks (link domain)
  // ----------------------------------------------------------------
  logic [2:0] rx_seq_q;           // Expected Rx header sequence number
  logic       hp_bad_w;           // Header packet error
  logic       seq_bad_w;          // Sequence mismatch on good packet

  // A K-symbol blocking the checks counts only in Gen 1
  assign hp_bad_w  = hdr_i.strobe & (~hdr_i.crc5_ok | ~hdr_i.crc16_ok
                     | (hdr_i.k_sym & ~gen2_l));
  assign seq_bad_w = hdr_i.strobe & ~hp_bad_w & (hdr_i.seq != rx_seq_q);

  // Sequence advances on each good, in-order packet; reset on U0 entry
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_seq_q <= SEQ_RST;
    end else if (u0_pulse_l) begin
      rx_seq_q <= SEQ_RST;
    end else if (hdr_i.strobe & ~hp_bad_w & ~seq_bad_w) begin
      rx_seq_q <= rx_seq_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Link command validity (link domain)
  // ----------------------------------------------------------------
  // Frame detect: three of four symbols, any one position corrupt
  function automatic logic three_of_four(input logic [3:0] v);
    three_of_four = (v == 4'hF) | (v == 4'hE) | (v == 4'hD)
                  | (v == 4'hB) | (v == 4'h7);
  endfunction

  // A copy is usable when it decodes and passes CRC-5
  function automatic logic word_ok(input uled_lcw_s w);
    word_ok = w.defined & w.crc_ok;
  endfunction

  logic      lc_det_w;            // Link command framing detected
  logic      lc_same_w;           // Both copies equal and good
  logic      lc_one_w;            // Exactly one good copy
  logic      lc_ok_w;             // Command accepted
  uled_lcw_s lc_w;                // Accepted copy

  assign lc_det_w  = lcmd_i.strobe & three_of_four(lcmd_i.slc_ok);
  assign lc_same_w = (lcmd_i.w0 == lcmd_i.w1) & word_ok(lcmd_i.w0);
  assign lc_one_w  = word_ok(lcmd_i.w0) ^ word_ok(lcmd_i.w1);
  assign lc_ok_w   = lc_det_w & (lc_same_w | (gen2_l & lc_one_w));
  assign lc_w      = word_ok(lcmd_i.w0) ? lcmd_i.w0 : lcmd_i.w1;

  // ----------------------------------------------------------------
  // Advertisement tracking and flow checks (link domain)
  // ----------------------------------------------------------------
  logic       adv_rx_q;           // Partner sequence advert received
  logic       crd1_rx_q;          // Partner (Type 1) credits received
  logic       crd2_rx_q;          // Partner Type 2 credits received
  logic [2:0] ack_seq_q;          // ACK Tx header sequence number
  logic [2:0] good_last_q;        // Last LGOOD_n value
  logic [1:0] ltr1_q;             // Expected next credit letter, type 1
  logic [1:0] ltr2_q;             // Expected next credit letter, type 2
  logic       is_good_w;          // Valid LGOOD_n
  logic       is_crd1_w;          // Valid credit, type 1 or Gen 1
  logic       is_crd2_w;          // Valid Type 2 credit
  logic       is_go_w;            // Valid LGO_Ux
  logic       good_miss_w;        // LGOOD_n not in numerical order
  logic       ack_bad_w;          // LGOOD_n differs from ACK number
  logic       crd_miss_w;         // Credit letter skipped
  logic       adv_bad_w;          // Credit or LGO_Ux before the advert
  logic       crd_bad_w;          // LGO_Ux before credits
  logic       crd_need_w;         // Credits required for LGO_Ux
  logic       adv_live_w;         // Advert held and not being cleared

  assign is_good_w = lc_ok_w & (lc_w.kind == ULED_LC_GOOD);
  assign is_crd1_w = lc_ok_w & (lc_w.kind == ULED_LC_CRD1);
  assign is_crd2_w = lc_ok_w & (lc_w.kind == ULED_LC_CRD2) & gen2_l;
  assign is_go_w   = lc_ok_w & (lc_w.kind == ULED_LC_GO_UX);

  // First LGOOD_n after U0 entry is the advertisement and is not checked
  assign adv_live_w  = adv_rx_q & ~u0_pulse_l;
  assign good_miss_w = is_good_w & adv_live_w & (lc_w.arg != good_last_q + 3'h1);
  assign ack_bad_w   = is_good_w & adv_live_w & (lc_w.arg != ack_seq_q);
  assign crd_miss_w  = (is_crd1_w & (lc_w.arg[1:0] != ltr1_q))
                     | (is_crd2_w & (lc_w.arg[1:0] != ltr2_q));
  assign adv_bad_w   = ~adv_live_w & (is_crd1_w | is_crd2_w | is_go_w);
  assign crd_need_w  = u0_pulse_l | (gen2_l ? ~(crd1_rx_q & crd2_rx_q) : ~crd1_rx_q);
  assign crd_bad_w   = adv_live_w & is_go_w & crd_need_w;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adv_rx_q    <= 1'b0;
      crd1_rx_q   <= 1'b0;
      crd2_rx_q   <= 1'b0;
      ack_seq_q   <= SEQ_RST;
      good_last_q <= SEQ_RST;
      ltr1_q      <= LTR_RST;
      ltr2_q      <= LTR_RST;
    end else begin
      // Fresh U0: advertisements start over; a command in the same
      // cycle comes after the clear, so its set wins
      if (u0_pulse_l) begin
        adv_rx_q  <= 1'b0;
        crd1_rx_q <= 1'b0;
        crd2_rx_q <= 1'b0;
        ltr1_q    <= LTR_RST;
        ltr2_q    <= LTR_RST;
      end
      if (is_good_w) begin
        adv_rx_q    <= 1'b1;
        good_last_q <= lc_w.arg;
        // Advert seeds the ACK number; later ones advance it
        ack_seq_q   <= adv_live_w ? ack_seq_q + 3'h1 : lc_w.arg + 3'h1;
      end
      if (is_crd1_w) begin
        crd1_rx_q <= 1'b1;
        ltr1_q    <= lc_w.arg[1:0] + 2'h1;
      end
      if (is_crd2_w) begin
        crd2_rx_q <= 1'b1;
        ltr2_q    <= lc_w.arg[1:0] + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link-domain events to the core domain by toggles
  // ----------------------------------------------------------------
  uled_evt_s        evt_l;        // Link-domain one-cycle events
  logic             lc_ok_tgl_q;  // Valid command toggle
  logic [EVT_W-1:0] evt_tgl_q;    // Event toggles
  logic             hdr_good_l;   // Header received cleanly

  assign hdr_good_l = hdr_i.strobe & ~hp_bad_w & ~seq_bad_w;

  always_comb begin
    evt_l             = '0;
    evt_l.hp_err      = hp_bad_w;
    evt_l.seq_err     = seq_bad_w;
    evt_l.lc_bad      = lc_det_w & ~lc_ok_w;
    evt_l.good_miss   = good_miss_w;
    evt_l.crd_miss    = crd_miss_w;
    evt_l.ack_err     = ack_bad_w;
    evt_l.adv_err     = adv_bad_w;
    evt_l.crd_adv_err = crd_bad_w;
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_tgl_q   <= '0;
      lc_ok_tgl_q <= 1'b0;
    end else begin
      evt_tgl_q   <= evt_tgl_q ^ evt_l;
      lc_ok_tgl_q <= lc_ok_tgl_q ^ lc_ok_w;
    end
  end

  // Header strobes cross separately to the core side for the fail run and the early header checks
  logic hdr_good_tgl_q;           // Clean header toggle
  logic hdr_t1_tgl_q;             // Header-type-1 arrival toggle
  logic hdr_t2_tgl_q;             // Type 2 header arrival toggle
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hdr_good_tgl_q <= 1'b0;
      hdr_t1_tgl_q   <= 1'b0;
      hdr_t2_tgl_q   <= 1'b0;
    end else begin
      hdr_good_tgl_q <= hdr_good_tgl_q ^ hdr_good_l;
      hdr_t1_tgl_q   <= hdr_t1_tgl_q ^ (hdr_i.strobe & ~hdr_i.type2);
      hdr_t2_tgl_q   <= hdr_t2_tgl_q ^ (hdr_i.strobe & hdr_i.type2);
    end
  end

  // Core-side synchronisers: two stages plus one history stage
  localparam int unsigned XW = EVT_W + 4;
  logic [XW-1:0] x_s1_q;          // First stage
  logic [XW-1:0] x_s2_q;          // Second stage
  logic [XW-1:0] x_s3_q;          // History for edge detection
  logic [XW-1:0] x_pls_w;         // Recovered pulses

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_s1_q <= '0;
      x_s2_q <= '0;
      x_s3_q <= '0;
    end else begin
      x_s1_q <= {hdr_t2_tgl_q, hdr_t1_tgl_q, hdr_good_tgl_q, lc_ok_tgl_q, evt_tgl_q};
      x_s2_q <= x_s1_q;
      x_s3_q <= x_s2_q;
    end
  end

  assign x_pls_w = x_s2_q ^ x_s3_q;

  uled_evt_s evt_c;               // Events in core domain
  logic      lc_ok_c;             // Valid command pulse, core
  logic      hdr_good_c;          // Clean header pulse, core
  logic      hdr_t1_c;            // Type 1 header pulse, core
  logic      hdr_t2_c;            // Type 2 header pulse, core

  assign evt_c      = x_pls_w[EVT_W-1:0];
  assign lc_ok_c    = x_pls_w[EVT_W];
  assign hdr_good_c = x_pls_w[EVT_W+1];
  assign hdr_t1_c   = x_pls_w[EVT_W+2];
  assign hdr_t2_c   = x_pls_w[EVT_W+3];

  // ----------------------------------------------------------------
  // Core-side advertisement state and failure run
  // ----------------------------------------------------------------
  logic       adv_sent_q;         // Our sequence advert went out
  logic       crd1_sent_q;        // Our (Type 1) credits went out
  logic       crd2_sent_q;        // Our Type 2 credits went out
  logic [1:0] fail_run_q;         // Consecutive header failures
  logic       hdr_any_c;          // Any header arrived
  logic       early_hdr_w;        // Header before our advert
  logic       early_crd_w;        // Header before our credits of its type
  logic       fail3_w;            // Third consecutive failure

  assign hdr_any_c   = hdr_t1_c | hdr_t2_c;
  assign early_hdr_w = in_u0_i & hdr_any_c & ~adv_sent_q;
  assign early_crd_w = in_u0_i & adv_sent_q & ((hdr_t1_c & ~crd1_sent_q)
                     | (hdr_t2_c & gen2_i & ~crd2_sent_q)
                     | (hdr_t2_c & ~gen2_i & ~crd1_sent_q));
  assign fail3_w     = evt_c.hp_err & (fail_run_q == 2'(HP_FAIL_LIMIT - 1));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adv_sent_q  <= 1'b0;
      crd1_sent_q <= 1'b0;
      crd2_sent_q <= 1'b0;
      fail_run_q  <= 2'h0;
    end else begin
      // Set on send wins over the U0-entry clear
      adv_sent_q  <= sent_adv_i  | (adv_sent_q  & ~u0_entry_i);
      crd1_sent_q <= sent_crd1_i | (crd1_sent_q & ~u0_entry_i);
      crd2_sent_q <= sent_crd2_i | (crd2_sent_q & ~u0_entry_i);
      if (u0_entry_i | hdr_good_c | hp_rx_ok_i | fail3_w) begin
        fail_run_q <= 2'h0;
      end else if (evt_c.hp_err) begin
        fail_run_q <= fail_run_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Recovery request merge
  // ----------------------------------------------------------------
  logic recov_w;                  // Any Recovery cause this cycle
  logic role_miss_w;              // Role-specific missing command
  logic crd_to_w;                 // Credit timer expiry

  assign role_miss_w = dsp_i ? lup_miss_i : ldn_miss_i;
  assign crd_to_w    = credit_to_i | (gen2_i & credit2_to_i);
  // LPMA missing is left out on purpose: it only delays Ux entry
  assign recov_w = in_u0_i & (fail3_w | evt_c.seq_err | evt_c.good_miss
                 | pend_hp_to_i | evt_c.crd_miss | crd_to_w | pm_lc_to_i
                 | role_miss_w | evt_c.ack_err | evt_c.adv_err
                 | evt_c.crd_adv_err | early_hdr_w | early_crd_w);

  // Soft errors: in Gen 2 only, CRC failures that themselves do not force Recovery
  logic soft_w;                   // Soft error this cycle
  assign soft_w = gen2_i & evt_c.hp_err & ~fail3_w;

  // Saturating increment used by both counters
  function automatic logic [15:0] sat_inc(input logic [15:0] c);
    sat_inc = (c == CNT_MAX) ? c : c + 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Outputs and counters
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lbad_req_o     <= 1'b0;
      recov_req_o    <= 1'b0;
      ux_delay_o     <= 1'b0;
      evt_o          <= '0;
      lc_valid_o     <= 1'b0;
      link_err_cnt_o <= CNT_RST;
      soft_err_cnt_o <= CNT_RST;
    end else begin
      lbad_req_o  <= evt_c.hp_err & in_u0_i;
      recov_req_o <= recov_w;
      ux_delay_o  <= pma_miss_i;
      evt_o       <= evt_c;
      lc_valid_o  <= lc_ok_c;
      if (cnt_clr_i) begin
        link_err_cnt_o <= CNT_RST;
      end else if (recov_w) begin
        link_err_cnt_o <= sat_inc(link_err_cnt_o);
      end
      if (cnt_clr_i) begin
        soft_err_cnt_o <= CNT_RST;
      end else if (soft_w) begin
        soft_err_cnt_o <= sat_inc(soft_err_cnt_o);
      end
    end
  end

endmodule
